// *** hw/reset_cause_consts.svh ***
`ifndef RESET_CAUSE_CONSTS_SVH
`define RESET_CAUSE_CONSTS_SVH

// register select codes on the register port
`define REG_ADDR_W 2
`define ADDR_CAUSE_STATUS 2'h0
`define ADDR_FORCE_RESET 2'h1
`define ADDR_OPTIONS_ONE 2'h2

// cause status bit positions, and the force register bit
`define BIT_POR 7
`define BIT_PIN 6
`define BIT_WDOG 5
`define BIT_ILLEGAL_OPCODE_CAUSE 4
`define BIT_ILLEGAL_ADDRESS_CAUSE 3
`define BIT_LOC 2
`define BIT_LVD 1
`define BIT_FORCE 0

// options one layout and reset
`define OPT_TSEL_HI 7
`define OPT_TSEL_LO 6
`define OPT_STOP 5
`define OPT_PINSEL 3
`define OPT1_RST 8'hC0
`define OPT1_WMASK 8'hE8

// watchdog clear sequence
`define KICK_ARM 8'h55
`define KICK_FIRE 8'hAA

// watchdog counts
`define WD_CNT_W 19
`define LPO_OVF1 19'h00020
`define LPO_OVF2 19'h00100
`define LPO_OVF3 19'h00400
`define BUS_OVF1 19'h02000
`define BUS_OVF2 19'h10000
`define BUS_OVF3 19'h40000
`define BUS_WIN1 19'h01800
`define BUS_WIN2 19'h0C000
`define BUS_WIN3 19'h30000

// internal reset pulse length in clk cycles
`define HOLD_W 6
`define HOLD_CYC 6'h20

`endif

// *** hw/reset_cause_pkg.sv ***
package reset_cause_pkg;

  typedef struct packed {
    logic wr;
    logic [1:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic por;
    logic pin;
    logic wdog;
    logic illegal_opcode_cause;
    logic illegal_address_cause;
    logic clock_loss_cause;
    logic low_voltage_cause;
  } cause_t;

  typedef struct packed {
    logic [1:0] tsel;
    logic stop_permit;
    logic rsv4;
    logic pin_sel;
    logic [2:0] rsv;
  } opts_t;

  typedef enum logic {ST_RUN, ST_HOLD} rst_state_t;

endpackage

// *** hw/reset_cause_and_watchdog_config.sv ***
`timescale 1ns/1ps
`include "reset_cause_consts.svh"


module reset_cause_and_watchdog_config #(
  parameter logic [18:0] BUS_OVF1 = `BUS_OVF1,
  parameter logic [18:0] BUS_OVF2 = `BUS_OVF2,
  parameter logic [18:0] BUS_OVF3 = `BUS_OVF3,
  parameter logic [18:0] BUS_WIN1 = `BUS_WIN1,
  parameter logic [18:0] BUS_WIN2 = `BUS_WIN2,
  parameter logic [18:0] BUS_WIN3 = `BUS_WIN3
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // register port, user program and debug host
  input wire reset_cause_pkg::reg_req_t user_req_i,
  input wire reset_cause_pkg::reg_req_t dbg_req_i,
  input wire logic [1:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // pins and analog sources, asynchronous
  input wire logic ext_reset_n_i,
  input wire logic low_voltage_i,
  input wire logic lpo_clk_i,
  // cpu and clock events, same clock
  input wire logic illegal_opcode_i,
  input wire logic illegal_address_i,
  input wire logic clock_loss_i,
  input wire logic stop_exec_i,
  input wire logic background_halt_instruction_i,
  // configuration held elsewhere
  input wire logic background_mode_enable_i,
  input wire logic low_voltage_reset_enable_i,
  input wire logic watchdog_clock_select_i,
  input wire logic watchdog_window_mode_i,
  // results
  output logic mcu_reset_o,
  output logic stop_grant_o,
  output logic halt_grant_o,
  output logic two_wire_pin_select_o,
  output logic watchdog_enable_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [18:0] wd_limit(input logic bus_src, input logic [1:0] tsel);
    logic [18:0] v;
    v = 19'h00000;
    case (tsel)
      2'h1: v = bus_src ? BUS_OVF1 : `LPO_OVF1;
      2'h2: v = bus_src ? BUS_OVF2 : `LPO_OVF2;
      2'h3: v = bus_src ? BUS_OVF3 : `LPO_OVF3;
      default: v = 19'h00000;
    endcase
    return v;
  endfunction

  function automatic logic [18:0] wd_window(input logic [1:0] tsel);
    logic [18:0] v;
    v = 19'h00000;
    case (tsel)
      2'h1: v = BUS_WIN1;
      2'h2: v = BUS_WIN2;
      2'h3: v = BUS_WIN3;
      default: v = 19'h00000;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic pin_s1_r;
  logic pin_s2_r;
  logic lv_s1_r;
  logic lv_s2_r;
  logic lpo_s1_r;
  logic lpo_s2_r;
  logic lpo_s3_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      lv_s1_r <= 1'b0;
      lv_s2_r <= 1'b0;
      lpo_s1_r <= 1'b0;
      lpo_s2_r <= 1'b0;
      lpo_s3_r <= 1'b0;
    end else if (ce_i) begin
      pin_s1_r <= ext_reset_n_i;
      pin_s2_r <= pin_s1_r;
      lv_s1_r <= low_voltage_i;
      lv_s2_r <= lv_s1_r;
      lpo_s1_r <= lpo_clk_i;
      lpo_s2_r <= lpo_s1_r;
      lpo_s3_r <= lpo_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  reset_cause_pkg::rst_state_t state_r;
  reset_cause_pkg::cause_t cause_r;
  reset_cause_pkg::cause_t cause_nxt;
  reset_cause_pkg::opts_t opts_r;
  logic opts_locked_r;
  logic [`HOLD_W-1:0] hold_cnt_r;
  logic [18:0] wd_cnt_r;
  logic armed_r;

  logic running;
  logic wd_on;
  logic wd_tick;
  logic [18:0] limit;
  logic [18:0] window;
  logic status_wr;
  logic early;
  logic kick_ok;
  logic kick_bad;
  logic wd_ovf;
  logic wd_evt;
  logic pin_evt;
  logic illegal_opcode_cause_evt;
  logic lvd_evt;
  logic force_evt;
  logic any_evt;
  logic hold_keep;

  // ----------------------------------------------------------------
  // watchdog decode
  // ----------------------------------------------------------------
  assign running = (state_r == reset_cause_pkg::ST_RUN);
  assign wd_on = (opts_r.tsel != 2'h0);
  assign limit = wd_limit(watchdog_clock_select_i, opts_r.tsel);
  assign window = wd_window(opts_r.tsel);
  // bus source counts every enabled clock; low-power source counts its rising edges
  assign wd_tick = watchdog_clock_select_i | (lpo_s2_r & ~lpo_s3_r);
  assign wd_ovf = wd_on & wd_tick & (wd_cnt_r == limit - 19'h00001);

  assign status_wr = user_req_i.wr & (user_req_i.addr == `ADDR_CAUSE_STATUS);
  // window applies to the bus source only; low-power has no window
  assign early = watchdog_window_mode_i & watchdog_clock_select_i
    & (wd_cnt_r < window);
  assign kick_ok = status_wr & armed_r & (user_req_i.wdata == `KICK_FIRE) & ~early;
  assign kick_bad = wd_on & status_wr & (early
    | ((user_req_i.wdata != `KICK_ARM) & (user_req_i.wdata != `KICK_FIRE)));
  assign wd_evt = wd_ovf | kick_bad;

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  assign pin_evt = ~pin_s2_r;
  assign illegal_opcode_cause_evt = illegal_opcode_i
    | (stop_exec_i & ~opts_r.stop_permit)
    | (background_halt_instruction_i & ~background_mode_enable_i);
  assign lvd_evt = lv_s2_r & low_voltage_reset_enable_i;
  // user writes to the force register never reach here
  assign force_evt = dbg_req_i.wr & (dbg_req_i.addr == `ADDR_FORCE_RESET)
    & dbg_req_i.wdata[`BIT_FORCE];
  assign any_evt = pin_evt | wd_evt | illegal_opcode_cause_evt | illegal_address_i
    | clock_loss_i | lvd_evt | force_evt;
  // stretch the internal reset while a level source is still asserted
  assign hold_keep = pin_evt | lvd_evt;

  always_comb begin
    cause_nxt.por = 1'b0;
    cause_nxt.pin = pin_evt;
    cause_nxt.wdog = wd_evt;
    cause_nxt.illegal_opcode_cause = illegal_opcode_cause_evt;
    cause_nxt.illegal_address_cause = illegal_address_i;
    cause_nxt.clock_loss_cause = clock_loss_i;
    cause_nxt.low_voltage_cause = lvd_evt;
    if (force_evt) begin
      cause_nxt = '0;
    end
  end

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= reset_cause_pkg::ST_HOLD;
      hold_cnt_r <= '0;
      mcu_reset_o <= 1'b1;
    end else if (ce_i) begin
      case (state_r)
        reset_cause_pkg::ST_RUN: begin
          if (any_evt) begin
            state_r <= reset_cause_pkg::ST_HOLD;
            hold_cnt_r <= '0;
            mcu_reset_o <= 1'b1;
          end
        end
        reset_cause_pkg::ST_HOLD: begin
          if (hold_cnt_r != `HOLD_CYC - `HOLD_W'(1)) begin
            hold_cnt_r <= hold_cnt_r + `HOLD_W'(1);
          end else if (!hold_keep) begin
            state_r <= reset_cause_pkg::ST_RUN;
            mcu_reset_o <= 1'b0;
          end
        end
        default: begin
          state_r <= reset_cause_pkg::ST_HOLD;
          hold_cnt_r <= '0;
          mcu_reset_o <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // cause flags
  // ----------------------------------------------------------------
  // captured once at reset entry, then frozen until the next entry
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cause_r <= '0;
      cause_r.por <= 1'b1;
      cause_r.low_voltage_cause <= 1'b1;
    end else if (ce_i) begin
      if (running && any_evt) begin
        cause_r <= cause_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // options one, write once
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      opts_r <= `OPT1_RST;
      opts_locked_r <= 1'b0;
    end else if (ce_i) begin
      if (!running) begin
        opts_r <= `OPT1_RST;
        opts_locked_r <= 1'b0;
      end else if (user_req_i.wr && user_req_i.addr == `ADDR_OPTIONS_ONE
          && !opts_locked_r) begin
        opts_r <= user_req_i.wdata & `OPT1_WMASK;
        opts_locked_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wd_cnt_r <= '0;
      armed_r <= 1'b0;
    end else if (ce_i) begin
      if (!running || kick_ok) begin
        wd_cnt_r <= '0;
        armed_r <= 1'b0;
      end else begin
        if (wd_on && wd_tick) begin
          wd_cnt_r <= wd_cnt_r + 19'h00001;
        end
        if (status_wr) begin
          armed_r <= (user_req_i.wdata == `KICK_ARM);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // stop and halt grants
  // ----------------------------------------------------------------
  // a grant is never given in the cycle a reset is being entered
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stop_grant_o <= 1'b0;
      halt_grant_o <= 1'b0;
    end else if (ce_i) begin
      stop_grant_o <= running & ~any_evt & stop_exec_i;
      halt_grant_o <= running & ~any_evt & background_halt_instruction_i;
    end
  end

  // ----------------------------------------------------------------
  // read port and configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
      two_wire_pin_select_o <= 1'b0;
      watchdog_enable_o <= 1'b0;
    end else if (ce_i) begin
      case (rd_addr_i)
        `ADDR_CAUSE_STATUS: rd_data_o <= {cause_r, 1'b0};
        `ADDR_FORCE_RESET: rd_data_o <= 8'h00;
        `ADDR_OPTIONS_ONE: rd_data_o <= opts_r;
        default: rd_data_o <= 8'h00;
      endcase
      two_wire_pin_select_o <= opts_r.pin_sel;
      watchdog_enable_o <= running & wd_on;
    end
  end

endmodule

// *** verif/reset_cause_sva.sv ***
`timescale 1ns/1ps
module reset_cause_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // inputs watched
  input wire reset_cause_pkg::reg_req_t user_req_i,
  input wire reset_cause_pkg::reg_req_t dbg_req_i,
  input wire logic [1:0] rd_addr_i,
  input wire logic ext_reset_n_i,
  input wire logic illegal_opcode_i,
  input wire logic stop_exec_i,
  input wire logic background_halt_instruction_i,
  input wire logic background_mode_enable_i,
  // outputs watched
  input wire logic [7:0] rd_data_o,
  input wire logic mcu_reset_o,
  input wire logic stop_grant_o,
  input wire logic halt_grant_o,
  input wire logic watchdog_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic run;
  logic bad_kick;
  assign run = ce_i && !mcu_reset_o;
  assign bad_kick = run && watchdog_enable_o && user_req_i.wr && user_req_i.addr == 2'h0
    && user_req_i.wdata != 8'h55 && user_req_i.wdata != 8'hAA;
  // --------------------------------
  // reset entry and hold
  // --------------------------------
  sequence s_hold;
    mcu_reset_o [*8];
  endsequence
  sequence s_pin_low;
    run && !ext_reset_n_i ##1 !ext_reset_n_i;
  endsequence
  property p_illegal_opcode_cause;
    run && illegal_opcode_i |=> s_hold;
  endproperty
  a_illegal_opcode_cause: assert property (p_illegal_opcode_cause) else $error("illegal opcode gave no reset");
  property p_hold;
    $rose(mcu_reset_o) |-> s_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("reset pulse too short");
  property p_pin;
    s_pin_low |-> ##[0:3] mcu_reset_o;
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin ignored");
  property p_stop;
    run && stop_exec_i |=> stop_grant_o != mcu_reset_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop neither granted nor reset");
  property p_halt_ok;
    run && background_halt_instruction_i && background_mode_enable_i
      |=> halt_grant_o && !mcu_reset_o;
  endproperty
  a_halt_ok: assert property (p_halt_ok) else $error("halt not granted");
  property p_halt_bad;
    run && background_halt_instruction_i && !background_mode_enable_i
      |=> mcu_reset_o && !halt_grant_o;
  endproperty
  a_halt_bad: assert property (p_halt_bad) else $error("halt without debug not reset");
  property p_force_rd;
    ce_i && rd_addr_i == 2'h1 |=> rd_data_o == 8'h00;
  endproperty
  a_force_rd: assert property (p_force_rd) else $error("force register read nonzero");
  property p_bad_kick;
    bad_kick |-> ##[1:3] mcu_reset_o;
  endproperty
  a_bad_kick: assert property (p_bad_kick) else $error("bad clear value ignored");
  property p_dbg;
    run && dbg_req_i.wr && dbg_req_i.addr == 2'h1 && dbg_req_i.wdata[0] |-> ##[1:2] mcu_reset_o;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug force gave no reset");
  property p_wd_off;
    $rose(mcu_reset_o) |=> !watchdog_enable_o;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog on during reset");
endmodule

bind reset_cause_and_watchdog_config reset_cause_sva u_reset_cause_sva (.clk_i, .sys_rst_i,
  .ce_i, .user_req_i, .dbg_req_i, .rd_addr_i, .ext_reset_n_i, .illegal_opcode_i, .stop_exec_i,
  .background_halt_instruction_i, .background_mode_enable_i, .rd_data_o, .mcu_reset_o,
  .stop_grant_o, .halt_grant_o, .watchdog_enable_o);

// *** verif/reg_host_model.sv ***
`timescale 1ns/1ps
module reg_host_model (
  // clock
  input wire logic clk_i,
  // requests toward the block
  output reset_cause_pkg::reg_req_t user_req_o,
  output reset_cause_pkg::reg_req_t dbg_req_o
);
  initial begin
    user_req_o = '0;
    dbg_req_o = '0;
  end
  // --------------------------------
  // bus cycles
  // --------------------------------
  // idle cycle after each pulse, and released fields show inverted garbage
  task automatic user_write(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk_i);
    user_req_o = {1'h1, a, d};
    @(negedge clk_i);
    user_req_o = {1'h0, ~a, ~d};
  endtask
  task automatic kick();
    user_write(2'h0, 8'h55);
    user_write(2'h0, 8'hAA);
  endtask
  // only the serial debug channel may carry the force bit
  task automatic dbg_write(input logic [1:0] a, input logic [7:0] d);
    @(negedge clk_i);
    dbg_req_o = {1'h1, a, d};
    @(negedge clk_i);
    dbg_req_o = {1'h0, ~a, ~d};
  endtask
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  reset_cause_pkg::reg_req_t user_req;
  reset_cause_pkg::reg_req_t dbg_req;
  logic [1:0] rd_addr = 2'h0;
  logic [6:0] ev = 7'h00;
  logic bgen = 1'h1;
  logic wwin = 1'h0;
  logic ce = 1'h1;
  logic lpo = 1'h0;
  logic lvre = 1'h1;
  logic wcs = 1'h1;
  logic [7:0] rd_data;
  logic mcu_rst, stop_g, halt_g, pin_sel, wd_en;
  logic [7:0] exp_tab [5] = '{8'h10, 8'h08, 8'h04, 8'h40, 8'h02};
  int num_errors = 0;
  int comparisons = 0;
  always #2.5 clk_i = ~clk_i;
  // stand-in for the slow low-power clock, one rising edge every 4 cycles
  always begin
    repeat (2) @(negedge clk_i);
    lpo = ~lpo;
  end

  reg_host_model u_reg_host_model (.clk_i(clk_i), .user_req_o(user_req), .dbg_req_o(dbg_req));
  // short counts for timeout code one keep the run brief; longer codes never expire here
  reset_cause_and_watchdog_config #(.BUS_OVF1(19'h00040), .BUS_WIN1(19'h00030)
  ) u_reset_cause_and_watchdog_config (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
    .user_req_i(user_req), .dbg_req_i(dbg_req), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
    .ext_reset_n_i(~ev[3]), .low_voltage_i(ev[4]), .lpo_clk_i(lpo),
    .illegal_opcode_i(ev[0]), .illegal_address_i(ev[1]), .clock_loss_i(ev[2]),
    .stop_exec_i(ev[5]), .background_halt_instruction_i(ev[6]),
    .background_mode_enable_i(bgen), .low_voltage_reset_enable_i(lvre),
    .watchdog_clock_select_i(wcs), .watchdog_window_mode_i(wwin), .mcu_reset_o(mcu_rst),
    .stop_grant_o(stop_g), .halt_grant_o(halt_g), .two_wire_pin_select_o(pin_sel),
    .watchdog_enable_o(wd_en));

  // --------------------------------
  // helpers
  // --------------------------------
  task automatic summarize();
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input string what, input logic [1:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    rd_addr = a;
    @(negedge clk_i);
    check(what, rd_data, exp);
  endtask
  task automatic wait_rst(input logic v, input int n);
    for (int i = 0; i < n && mcu_rst !== v; i++) @(negedge clk_i);
    if (mcu_rst !== v) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic after_rst(input logic [7:0] exp);
    wait_rst(1'h1, 4);
    wait_rst(1'h0, 200);
    rd_chk("cause_status", 2'h0, exp);
  endtask
  task automatic fire(input int k, input int cyc);
    @(negedge clk_i);
    ev[k] = 1'h1;
    repeat (cyc) @(negedge clk_i);
    ev[k] = 1'h0;
  endtask

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'h0;
    wait_rst(1'h0, 100);
    rd_chk("cause_status", 2'h0, 8'h82);
    rd_chk("force_reg", 2'h1, 8'h00);
    rd_chk("unmapped", 2'h3, 8'h00);
    u_reg_host_model.user_write(2'h1, 8'h01);
    check("mcu_reset", {7'h00, mcu_rst}, 8'h00);
    u_reg_host_model.user_write(2'h2, 8'h68);
    u_reg_host_model.user_write(2'h2, 8'h00);
    rd_chk("options_one", 2'h2, 8'h68);
    check("pin_select", {7'h00, pin_sel}, 8'h01);
    u_reg_host_model.kick();
    fire(5, 1);
    check("stop_grant", {7'h00, stop_g}, 8'h01);
    fire(6, 1);
    check("halt_grant", {7'h00, halt_g}, 8'h01);
    // an event while the clock enable is low must be frozen out
    ce = 1'h0;
    fire(0, 1);
    ce = 1'h1;
    check("frozen_reset", {7'h00, mcu_rst}, 8'h00);
    u_reg_host_model.kick();
    repeat (56) @(negedge clk_i);
    check("early_overflow", {7'h00, mcu_rst}, 8'h00);
    wait_rst(1'h1, 12);
    after_rst(8'h20);
    wwin = 1'h1;
    u_reg_host_model.user_write(2'h2, 8'h40);
    u_reg_host_model.kick();
    after_rst(8'h20);
    u_reg_host_model.user_write(2'h2, 8'h40);
    repeat (48) @(negedge clk_i);
    u_reg_host_model.kick();
    check("late_kick", {7'h00, mcu_rst}, 8'h00);
    fire(5, 1);
    after_rst(8'h10);
    wwin = 1'h0;
    u_reg_host_model.user_write(2'h0, 8'h12);
    after_rst(8'h20);
    u_reg_host_model.user_write(2'h2, 8'h00);
    // enable output follows the options register one edge later
    @(negedge clk_i);
    check("wd_enable", {7'h00, wd_en}, 8'h00);
    u_reg_host_model.user_write(2'h0, 8'h12);
    repeat (4) @(negedge clk_i);
    check("mcu_reset", {7'h00, mcu_rst}, 8'h00);
    bgen = 1'h0;
    fire(6, 1);
    after_rst(8'h10);
    bgen = 1'h1;
    u_reg_host_model.dbg_write(2'h1, 8'h01);
    after_rst(8'h00);
    // low-power source: slower count, and no window even in windowed mode
    wcs = 1'h0;
    wwin = 1'h1;
    u_reg_host_model.user_write(2'h2, 8'h40);
    u_reg_host_model.kick();
    repeat (100) @(negedge clk_i);
    check("lpo_overflow", {7'h00, mcu_rst}, 8'h00);
    wait_rst(1'h1, 60);
    wwin = 1'h0;
    wcs = 1'h1;
    after_rst(8'h20);
    // low-voltage trip with its reset disabled must be ignored
    lvre = 1'h0;
    fire(4, 4);
    repeat (3) @(negedge clk_i);
    check("lvd_disabled", {7'h00, mcu_rst}, 8'h00);
    lvre = 1'h1;
    for (int k = 0; k < 5; k++) begin
      fire(k, (k >= 3) ? 4 : 1);
      after_rst(exp_tab[k]);
    end
    summarize();
  end
endmodule
